// ### rtl/ogp_gpio_port.sv
`timescale 1ns/100ps
// Functional notes
// - Off crystal mode, pins 0 and 1 are open with direction 0, else drive the latch.
// - Oscillator control bits 7, 3 and 1 all set put pins 3 and 4 in ceramic mode.
// - Off ceramic mode, pins 3 and 4 are open with direction 0, else drive the latch.
// - Pin 2 is open, pulled up or driven from its latch and direction bits.
// - In pause mode every pin holds the output state it had on entry.
// - In deep stop, general-purpose outputs keep their state from entry.
// - In deep stop, crystal-owned pins 0 and 1 return to port control.
// - In either deep stop, ceramic-owned pins 3 and 4 return to port control.
// - In deep stop with subclock, general-purpose outputs keep their entry state.
// - In deep stop with subclock, crystal pins 0 and 1 stay as on entry.
// - Latch and direction registers are read-write, five bits, reset to zero.
// - The pin input location returns the live level of all five pins.
// - An enabled oscillator overrides latch and direction on its shared pins.
module ogp_gpio_port (
    input  wire logic                          core_clk,                // System clock, 40 MHz
    input  wire logic                          rst_b,                   // Sync reset, active low
    input  wire logic                          ce,                      // Clock enable
    input  wire logic                          wb_cyc_i,                // Bus cycle
    input  wire logic                          wb_stb_i,                // Bus strobe
    input  wire logic                          wb_we_i,                 // Write enable
    input  wire logic [ogp_pkg::WB_ADR_W-1:0]  wb_adr_i,                // Byte address
    input  wire logic [ogp_pkg::WB_DAT_W-1:0]  wb_dat_i,                // Write data
    input  wire logic [ogp_pkg::WB_SEL_W-1:0]  wb_sel_i,                // Byte lanes
    output logic      [ogp_pkg::WB_DAT_W-1:0]  wb_dat_o,                // Read data
    output logic                               wb_ack_o,                // Acknowledge
    input  wire logic                          pause_mode,              // CPU paused
    input  wire logic                          deep_stop_mode,          // Deep stop
    input  wire logic                          deep_stop_subclock_mode, // Deep stop, subclock on
    input  wire logic [ogp_pkg::PIN_COUNT-1:0] pin_in,                  // Pad levels
    output logic      [ogp_pkg::PIN_COUNT-1:0] pin_out,                 // Pad output value
    output logic      [ogp_pkg::PIN_COUNT-1:0] pin_oe,                  // Pad output enable
    output logic      [ogp_pkg::PIN_COUNT-1:0] pin_pullup,              // Pull-up enable
    output logic                               crystal_osc_en,          // Crystal owns pins 0,1
    output logic                               ceramic_osc_en           // Ceramic owns pins 3,4
);
    import ogp_pkg::*;

    logic [PIN_COUNT-1:0] port_output_latch;
    logic [PIN_COUNT-1:0] port_direction_reg;
    logic [PIN_COUNT-1:0] port_pin_input;
    logic [IDX_W-1:0]     bus_idx;
    logic                 bus_req;
    logic                 wr_commit;
    logic                 lane0_wr;
    logic [WB_DAT_W-1:0]  next_rdata;
    ogp_mode_type         cur_mode;
    logic [PIN_COUNT-1:0] owned;
    logic [PIN_COUNT-1:0] gpio_oe;
    logic [PIN_COUNT-1:0] gpio_out;
    logic [PIN_COUNT-1:0] gpio_pu;
    logic [PIN_COUNT-1:0] release_pin;
    logic [PIN_COUNT-1:0] next_oe;
    logic [PIN_COUNT-1:0] next_out;
    logic [PIN_COUNT-1:0] next_pu;
    logic                 next_xt_en;
    logic                 next_cf_en;
    logic                 xt_at_entry;
    logic                 cf_at_entry;

    ogp_osc_if osc ();

    // Oscillator control decode
    ogp_osc_decode u_osc_decode (
        .osc (osc.dec)
    );

    // Pad levels come from outside the clock domain
    ogp_sync u_pin_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .ce       (ce),
        .d_async  (pin_in),
        .q_sync   (port_pin_input)
    );

    // Bus decode: registers sit one per word at four times their index
    assign bus_idx   = wb_adr_i[WB_ADR_W-1:2];
    assign bus_req   = wb_cyc_i & wb_stb_i;
    assign wr_commit = bus_req & wb_we_i & wb_ack_o;
    assign lane0_wr  = wr_commit & wb_sel_i[0];

    // Ack one cycle after the request is taken, dropped in the following cycle
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
        end else if (ce) begin
            wb_ack_o <= bus_req & ~wb_ack_o;
        end
    end

    // Read mux; upper bits and unmapped words read as zero
    always_comb begin
        next_rdata = '0;
        unique case (bus_idx)
            IDX_LATCH: begin
                next_rdata[PIN_COUNT-1:0] = port_output_latch;
            end
            IDX_PIN: begin
                next_rdata[PIN_COUNT-1:0] = port_pin_input;
            end
            IDX_DIR: begin
                next_rdata[PIN_COUNT-1:0] = port_direction_reg;
            end
            IDX_OSC: begin
                next_rdata[REG_W-1:0] = osc.osc_control_reg;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // Read data is captured with the ack and stands while ack is high
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wb_dat_o <= '0;
        end else if (ce && bus_req && !wb_ack_o) begin
            wb_dat_o <= next_rdata;
        end
    end

    // Output latch; writes land whatever owns the pins so they apply later
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            port_output_latch <= LATCH_RST;
        end else if (ce && lane0_wr && bus_idx == IDX_LATCH) begin
            port_output_latch <= wb_dat_i[PIN_COUNT-1:0];
        end
    end

    // Direction register; bits above the port width are dropped
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            port_direction_reg <= DIR_RST;
        end else if (ce && lane0_wr && bus_idx == IDX_DIR) begin
            port_direction_reg <= wb_dat_i[PIN_COUNT-1:0];
        end
    end

    // Oscillator control register
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            osc.osc_control_reg <= OSC_RST;
        end else if (ce && lane0_wr && bus_idx == IDX_OSC) begin
            osc.osc_control_reg <= wb_dat_i[REG_W-1:0];
        end
    end

    // Power mode; deep stop outranks subclock stop, which outranks pause
    always_comb begin
        if (deep_stop_mode) begin
            cur_mode = MODE_STOP;
        end else if (deep_stop_subclock_mode) begin
            cur_mode = MODE_SUBCLK;
        end else if (pause_mode) begin
            cur_mode = MODE_PAUSE;
        end else begin
            cur_mode = MODE_RUN;
        end
    end

    // Per-pin port function and oscillator ownership
    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i++) begin : g_pin
            // Oscillator wins over latch and direction
            assign owned[i] = (XT_PINS[i] & osc.crystal_osc_mode)
                            | (CF_PINS[i] & osc.ceramic_osc_mode);
            // Direction 1 drives the latch, direction 0 leaves the pad open
            assign gpio_oe[i]  = port_direction_reg[i];
            assign gpio_out[i] = port_output_latch[i];
            // Only pin 2 has a pull-up, on with direction 0 and latch 1
            assign gpio_pu[i]  = PULLUP_PINS[i] & ~port_direction_reg[i]
                               & port_output_latch[i];
            // Pins handed back from an oscillator during deep stop
            // Ownership is taken from entry, since the live enables drop in stop
            assign release_pin[i] =
                  (cur_mode == MODE_STOP   & XT_PINS[i] & xt_at_entry)
                | (cur_mode == MODE_STOP   & CF_PINS[i] & cf_at_entry)
                | (cur_mode == MODE_SUBCLK & CF_PINS[i] & cf_at_entry);
        end
    endgenerate

    // Next pad state; low-power modes keep the state held at entry, save oscillator pins released in a stop
    always_comb begin
        next_oe    = pin_oe;
        next_out   = pin_out;
        next_pu    = pin_pullup;
        next_xt_en = crystal_osc_en;
        next_cf_en = ceramic_osc_en;
        unique case (cur_mode)
            MODE_RUN: begin
                // An owned pin is left to the oscillator cell, port drive off
                next_oe    = gpio_oe & ~owned;
                next_out   = gpio_out & ~owned;
                next_pu    = gpio_pu & ~owned;
                next_xt_en = osc.crystal_osc_mode;
                next_cf_en = osc.ceramic_osc_mode;
            end
            MODE_PAUSE: begin
                // Everything, oscillator pins included, stays as on entry
                next_oe    = pin_oe;
                next_out   = pin_out;
                next_pu    = pin_pullup;
            end
            MODE_STOP: begin
                // Port pins hold; oscillator pins fall back to port control
                next_oe    = (pin_oe & ~release_pin) | (gpio_oe & release_pin);
                next_out   = (pin_out & ~release_pin) | (gpio_out & release_pin);
                next_pu    = (pin_pullup & ~release_pin) | (gpio_pu & release_pin);
                next_xt_en = 1'b0;
                next_cf_en = 1'b0;
            end
            MODE_SUBCLK: begin
                // Crystal pins keep running as on entry, ceramic pins return
                next_oe    = (pin_oe & ~release_pin) | (gpio_oe & release_pin);
                next_out   = (pin_out & ~release_pin) | (gpio_out & release_pin);
                next_pu    = (pin_pullup & ~release_pin) | (gpio_pu & release_pin);
                next_xt_en = crystal_osc_en;
                next_cf_en = 1'b0;
            end
        endcase
    end

    // Pad drive registers; reset leaves every pin open with no pull-up
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pin_oe     <= '0;
            pin_out    <= '0;
            pin_pullup <= '0;
        end else if (ce) begin
            pin_oe     <= next_oe;
            pin_out    <= next_out;
            pin_pullup <= next_pu;
        end
    end

    // Ownership seen before a stop; frozen in either stop so released pins
    // keep following latch and direction for the whole stop
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            xt_at_entry <= 1'b0;
            cf_at_entry <= 1'b0;
        end else if (ce && (cur_mode == MODE_RUN || cur_mode == MODE_PAUSE)) begin
            xt_at_entry <= next_xt_en;
            cf_at_entry <= next_cf_en;
        end
    end

    // Oscillator ownership registers; held in pause, both cleared in deep stop, only ceramic cleared with subclock
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            crystal_osc_en <= 1'b0;
            ceramic_osc_en <= 1'b0;
        end else if (ce) begin
            crystal_osc_en <= next_xt_en;
            ceramic_osc_en <= next_cf_en;
        end
    end

endmodule

// ### rtl/ogp_osc_decode.sv
`timescale 1ns/100ps
module ogp_osc_decode (
    ogp_osc_if.dec osc   // Oscillator control and decoded modes
);
    import ogp_pkg::*;

    // Crystal needs both of its enable bits
    assign osc.crystal_osc_mode = osc.osc_control_reg[OSC_XT_B]
                                & osc.osc_control_reg[OSC_XT_A];
    // Ceramic needs all three of its enable bits
    assign osc.ceramic_osc_mode = osc.osc_control_reg[OSC_CF_C]
                                & osc.osc_control_reg[OSC_CF_B]
                                & osc.osc_control_reg[OSC_CF_A];
endmodule

// ### rtl/ogp_osc_if.sv
`timescale 1ns/100ps
interface ogp_osc_if;
    import ogp_pkg::*;
    logic [REG_W-1:0] osc_control_reg;   // Oscillator control word
    logic             crystal_osc_mode;  // Crystal owns pins 0 and 1
    logic             ceramic_osc_mode;  // Ceramic owns pins 3 and 4

    modport ctrl (output osc_control_reg, input crystal_osc_mode, ceramic_osc_mode);
    modport dec  (input osc_control_reg, output crystal_osc_mode, ceramic_osc_mode);
endinterface

// ### rtl/ogp_pkg.sv
package ogp_pkg;

    // Port geometry
    localparam int unsigned PIN_COUNT = 5;
    localparam int unsigned REG_W     = 8;
    localparam int unsigned WB_DAT_W  = 32;
    localparam int unsigned WB_ADR_W  = 18;
    localparam int unsigned WB_SEL_W  = 4;
    localparam int unsigned IDX_W     = 16;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [IDX_W-1:0] IDX_LATCH = 16'h7FD0;
    localparam logic [IDX_W-1:0] IDX_PIN   = 16'h7FD1;
    localparam logic [IDX_W-1:0] IDX_DIR   = 16'h7FD2;
    localparam logic [IDX_W-1:0] IDX_OSC   = 16'h7FD8;

    // Values after reset
    localparam logic [PIN_COUNT-1:0] LATCH_RST = 5'h00;
    localparam logic [PIN_COUNT-1:0] DIR_RST   = 5'h00;
    localparam logic [REG_W-1:0]     OSC_RST   = 8'h00;

    // Field positions in the oscillator control register
    localparam int unsigned OSC_XT_A  = 0;
    localparam int unsigned OSC_XT_B  = 2;
    localparam int unsigned OSC_CF_A  = 1;
    localparam int unsigned OSC_CF_B  = 3;
    localparam int unsigned OSC_CF_C  = 7;

    // Pin groups shared with oscillators, and the pull-up pin
    localparam logic [PIN_COUNT-1:0] XT_PINS     = 5'h03;
    localparam logic [PIN_COUNT-1:0] CF_PINS     = 5'h18;
    localparam logic [PIN_COUNT-1:0] PULLUP_PINS = 5'h04;

    // Low-power mode of the CPU, one-hot
    typedef enum logic [3:0] {
        MODE_RUN    = 4'b0001,
        MODE_PAUSE  = 4'b0010,
        MODE_STOP   = 4'b0100,
        MODE_SUBCLK = 4'b1000
    } ogp_mode_type;

endpackage

// ### rtl/ogp_sync.sv
`timescale 1ns/100ps
module ogp_sync (
    input  wire logic                          core_clk, // System clock
    input  wire logic                          rst_b,    // Synchronous reset, active low
    input  wire logic                          ce,       // Clock enable
    input  wire logic [ogp_pkg::PIN_COUNT-1:0] d_async,  // Levels from the pads
    output logic      [ogp_pkg::PIN_COUNT-1:0] q_sync    // Levels in the clock domain
);
    import ogp_pkg::*;

    logic [PIN_COUNT-1:0] meta;

    // Two stages; the first is read by the second alone to contain metastability
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            meta   <= '0;
            q_sync <= '0;
        end else if (ce) begin
            meta   <= d_async;
            q_sync <= meta;
        end
    end
endmodule

// ### verif/ogp_gpio_port_bench.sv
`timescale 1ns/100ps
module ogp_gpio_port_bench;
    import ogp_pkg::*;
    logic                 core_clk = 1'b0;
    logic                 rst_b;
    logic                 wb_cyc_i;
    logic                 wb_stb_i;
    logic                 wb_we_i;
    logic [WB_ADR_W-1:0]  wb_adr_i;
    logic [WB_DAT_W-1:0]  wb_dat_i;
    logic [WB_SEL_W-1:0]  wb_sel_i;
    logic [WB_DAT_W-1:0]  wb_dat_o;
    logic                 wb_ack_o;
    logic                 ce = 1'b1;
    logic                 pause_mode;
    logic                 deep_stop_mode;
    logic                 deep_stop_subclock_mode;
    logic [PIN_COUNT-1:0] pin_in;
    logic [PIN_COUNT-1:0] pin_out;
    logic [PIN_COUNT-1:0] pin_oe;
    logic [PIN_COUNT-1:0] pin_pullup;
    logic                 crystal_osc_en;
    logic                 ceramic_osc_en;
    logic [PIN_COUNT-1:0] ext_en;
    logic [PIN_COUNT-1:0] ext_val;
    logic [WB_DAT_W-1:0]  rd_val;
    int                   failures = 0;
    int                   samples_checked = 0;
    logic [7:0]           tbl_l [4] = '{8'h1A, 8'h04, 8'h1F, 8'h05};
    logic [7:0]           tbl_d [4] = '{8'h1C, 8'h00, 8'h1F, 8'h03};
    logic [7:0]           osc_v [5] = '{8'h05, 8'h04, 8'h8A, 8'h0A, 8'h8F};
    logic [7:0]           osc_e [5] = '{8'h1C, 8'h1F, 8'h07, 8'h1F, 8'h04};

    always #12.5 core_clk = ~core_clk;

    ogp_gpio_port DUT (.core_clk, .rst_b, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .pause_mode, .deep_stop_mode,
        .deep_stop_subclock_mode, .pin_in, .pin_out, .pin_oe, .pin_pullup,
        .crystal_osc_en, .ceramic_osc_en);
    ogp_pad_model u_pad (.core_clk, .pin_out, .pin_oe, .pin_pullup, .ext_en, .ext_val,
        .pad(pin_in));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic cycle; waits on ack with a bound so a dead slave ends the run
    task automatic bus(input logic we, input logic [15:0] idx, input logic [31:0] wd,
                       input logic [3:0] sel);
        int n;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'h0};
        wb_dat_i <= wd;
        wb_sel_i <= sel;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            finish_test();
        end
        rd_val = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        bus(1'b1, idx, {24'h000000, d}, 4'h1);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 32'h00000000, 4'hF);
        check(rd_val, {24'h000000, exp});
    endtask

    // Outputs settle one edge after a write; sampled mid-cycle
    task automatic pins(input logic [4:0] oe, input logic [4:0] drv, input logic [4:0] pu,
                        input logic xt, input logic cf);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        check({15'h0000, pin_oe, pin_out & pin_oe, pin_pullup, crystal_osc_en, ceramic_osc_en},
              {15'h0000, oe, drv, pu, xt, cf});
    endtask

    task automatic mode(input logic p, input logic d, input logic s);
        @(posedge core_clk);
        pause_mode <= p;
        deep_stop_mode <= d;
        deep_stop_subclock_mode <= s;
    endtask

    initial begin
        rst_b = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, pause_mode, deep_stop_mode, deep_stop_subclock_mode} = 6'h00;
        wb_adr_i = 18'h00000;
        wb_dat_i = 32'h00000000;
        wb_sel_i = 4'h0;
        ext_en = 5'h18;
        ext_val = 5'h10;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(IDX_LATCH, 8'h00);
        rd(IDX_DIR, 8'h00);
        pins(5'h00, 5'h00, 5'h00, 1'b0, 1'b0);
        wr(IDX_LATCH, 8'hFF);
        rd(IDX_LATCH, 8'h1F);
        wr(IDX_DIR, 8'hFF);
        bus(1'b1, IDX_DIR, 32'h00000000, 4'hE);
        rd(IDX_DIR, 8'h1F);
        wr(16'h7FD3, 8'hFF);
        rd(16'h7FD3, 8'h00);
        $display("test registers done");
        // Latch and direction combinations per pin, then a live pad read
        for (int i = 0; i < 4; i++) begin
            wr(IDX_LATCH, tbl_l[i]);
            wr(IDX_DIR, tbl_d[i]);
            pins(tbl_d[i][4:0], tbl_l[i][4:0] & tbl_d[i][4:0], tbl_l[i][4:0] & ~tbl_d[i][4:0] & 5'h04, 1'b0, 1'b0);
        end
        rd(IDX_PIN, 8'h15);
        $display("test port pins done");
        wr(IDX_LATCH, 8'h1F);
        wr(IDX_DIR, 8'h1F);
        for (int i = 0; i < 5; i++) begin
            wr(IDX_OSC, osc_v[i]);
            pins(osc_e[i][4:0], osc_e[i][4:0], 5'h00, osc_v[i][2] & osc_v[i][0], osc_v[i][7] & osc_v[i][3] & osc_v[i][1]);
        end
        rd(IDX_OSC, 8'h8F);
        wr(IDX_LATCH, 8'h00);
        rd(IDX_LATCH, 8'h00);
        wr(IDX_LATCH, 8'h1F);
        $display("test oscillators done");
        mode(1'b1, 1'b0, 1'b0);
        wr(IDX_LATCH, 8'h00);
        pins(5'h04, 5'h04, 5'h00, 1'b1, 1'b1);
        mode(1'b0, 1'b0, 1'b0);
        pins(5'h04, 5'h00, 5'h00, 1'b1, 1'b1);
        mode(1'b0, 1'b1, 1'b0);
        wr(IDX_LATCH, 8'h1B);
        pins(5'h1F, 5'h1B, 5'h00, 1'b0, 1'b0);
        mode(1'b0, 1'b0, 1'b0);
        pins(5'h04, 5'h00, 5'h00, 1'b1, 1'b1);
        mode(1'b0, 1'b0, 1'b1);
        wr(IDX_LATCH, 8'h1F);
        pins(5'h1C, 5'h18, 5'h00, 1'b1, 1'b0);
        mode(1'b0, 1'b0, 1'b0);
        $display("test low power modes done");
        finish_test();
    end
endmodule

bind ogp_gpio_port ogp_gpio_port_checker u_chk (.core_clk, .rst_b, .ce, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .pause_mode, .deep_stop_mode, .deep_stop_subclock_mode, .pin_out, .pin_oe,
    .pin_pullup, .crystal_osc_en, .ceramic_osc_en);

// ### verif/ogp_gpio_port_checker.sv
`timescale 1ns/100ps
module ogp_gpio_port_checker (
    input wire logic                          core_clk,                // Clock
    input wire logic                          rst_b,                   // Reset
    input wire logic                          ce,                      // Enable
    input wire logic                          wb_cyc_i,                // Cycle
    input wire logic                          wb_stb_i,                // Strobe
    input wire logic                          wb_ack_o,                // Ack
    input wire logic                          pause_mode,              // Pause
    input wire logic                          deep_stop_mode,          // Stop
    input wire logic                          deep_stop_subclock_mode, // Subclock stop
    input wire logic [ogp_pkg::PIN_COUNT-1:0] pin_out,                 // Drive value
    input wire logic [ogp_pkg::PIN_COUNT-1:0] pin_oe,                  // Drive enable
    input wire logic [ogp_pkg::PIN_COUNT-1:0] pin_pullup,              // Pull-up
    input wire logic                          crystal_osc_en,          // Crystal on
    input wire logic                          ceramic_osc_en           // Ceramic on
);
    import ogp_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // Mode qualifiers; priority keeps one hold rule active at a time
    logic hold_pause;
    logic hold_stop;
    logic hold_sub;
    assign hold_pause = pause_mode & ~deep_stop_mode & ~deep_stop_subclock_mode & ce & rst_b;
    assign hold_stop  = deep_stop_mode & ce & rst_b;
    assign hold_sub   = deep_stop_subclock_mode & ~deep_stop_mode & ce & rst_b;

    sequence bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
    endsequence

    ack_follows_req_a: assert property (bus_req |=> wb_ack_o)
        else $error("no ack one cycle after request");
    ack_single_a: assert property (wb_ack_o && ce |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    xt_owns_pins_a: assert property (crystal_osc_en |-> pin_oe[1:0] == 2'h0)
        else $error("crystal pins still driven");
    cf_owns_pins_a: assert property (ceramic_osc_en |-> pin_oe[4:3] == 2'h0)
        else $error("ceramic pins still driven");
    pullup_pin_two_a: assert property ((pin_pullup & ~PULLUP_PINS) == 5'h00)
        else $error("pull-up outside pin 2");
    pause_hold_a: assert property ($past(hold_pause) |-> $stable(pin_oe) && $stable(pin_out)
        && $stable(pin_pullup) && $stable(crystal_osc_en))
        else $error("pins moved in pause");
    stop_osc_off_a: assert property (hold_stop |=> !crystal_osc_en && !ceramic_osc_en)
        else $error("oscillator kept in deep stop");
    stop_pin_hold_a: assert property ($past(hold_stop) |-> $stable(pin_oe[2])
        && $stable(pin_out[2]))
        else $error("pin 2 moved in deep stop");
    sub_hold_a: assert property ($past(hold_sub) |-> $stable(crystal_osc_en)
        && $stable(pin_oe[2:0]) && $stable(pin_out[2:0]))
        else $error("pins 0 to 2 moved in subclock stop");
    sub_cf_off_a: assert property (hold_sub |=> !ceramic_osc_en)
        else $error("ceramic kept in subclock stop");
endmodule

// ### verif/ogp_pad_model.sv
`timescale 1ns/100ps
module ogp_pad_model (
    input  wire logic                          core_clk,   // Clock
    input  wire logic [ogp_pkg::PIN_COUNT-1:0] pin_out,    // Port drive value
    input  wire logic [ogp_pkg::PIN_COUNT-1:0] pin_oe,     // Port drive enable
    input  wire logic [ogp_pkg::PIN_COUNT-1:0] pin_pullup, // Port pull-up
    input  wire logic [ogp_pkg::PIN_COUNT-1:0] ext_en,     // Board drives pin
    input  wire logic [ogp_pkg::PIN_COUNT-1:0] ext_val,    // Board drive value
    output logic      [ogp_pkg::PIN_COUNT-1:0] pad         // Resolved pad level
);
    import ogp_pkg::*;
    logic [PIN_COUNT-1:0] float_q = 5'h0A;

    // Undriven pads wander so a stale level is never mistaken for a read
    always_ff @(posedge core_clk) begin
        float_q <= ~float_q;
    end

    // Port drive wins, then the board, then the pull-up, else floating
    assign pad = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
               | (~pin_oe & ~ext_en & pin_pullup)
               | (~pin_oe & ~ext_en & ~pin_pullup & float_q);
endmodule
